// ===== host_model.sv
// Host model that drives the register port and builds pattern files.
`timescale 1ns/1ps
module host_model (
  // Clock.
  input  wire logic        sys_clk_i,
  // Register port.
  output logic      [7:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  // Last pattern file built, kept so the bench can derive expectations.
  logic [7:0] pat [0:511];

  // Idle bus at time zero.
  initial
  begin
    addr_o  = 8'h00;
    wdata_o = 32'h0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // One access, then one idle edge so no strobe is assigned twice in a
  // time step; the slave never stalls, so the first edge takes it.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= w;
    rd_o    <= ~w;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    @(posedge sys_clk_i);
  endtask : xfer

  // Reserved bits fixed, burst in every byte for a continuous signal,
  // events in alternate bytes and restart only in the final byte.
  task automatic build(input int n, inout integer seed);
    int m;
    m = (n < 60) ? 60 : n;
    for (int i = 0; i < m; i++)
    begin
      pat[i]    = 8'h14;
      pat[i][0] = 1'($random(seed));
      pat[i][6] = i[0];
      pat[i][7] = (i == m - 1);
    end
  endtask : build

  // Opens a download, sends whole bytes and closes it with the length.
  task automatic send(input int n, input logic run);
    xfer(1'b1, pmp_pkg::OFS_CTRL, {28'h0, 1'b1, 2'h0, run});
    for (int i = 0; i < n; i++)
      xfer(1'b1, pmp_pkg::OFS_PDATA, {24'h0, pat[i]});
    xfer(1'b1, pmp_pkg::OFS_PLEN, 32'(n));
  endtask : send
endmodule : host_model

// ===== pattern_memory_playback.sv
// Pattern memory playback engine with downloads, checks and external data.
//
// How it works
// - Bit 0 of each byte is payload; ignored when the burst bit is 0.
// - Bit 2 turns RF on when 1, off when 0.
// - Bit 6 set gives one pulse on the event one output.
// - Bit 7 clear advances address; set marks end and restarts playback.
// - Download beyond pattern memory size is refused with error -223.
// - Framed user data restarts after the last full field of field_bits symbols.
// - Memory holds data and framing; host fills whole timeslots.
// - External serial data with its clock and sync is modulated.
// - External burst input frames external data, or internal framing.
// - Filters over 1024 taps, 2048 complex, are refused with -223.
// - Filter file larger than free storage reports error -321.
// - Filter symbol span over 32, 512 or 256 makes it unselectable.
`timescale 1ns/1ps
module pattern_memory_playback #(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW    = 8
) (
  // Clock and reset.
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // Register port.
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // External real-time data pins.
  input  wire logic        ext_data_i,
  input  wire logic        ext_data_clk_i,
  input  wire logic        ext_symbol_sync_i,
  input  wire logic        external_burst_input_i,
  // Modulator side.
  output logic             mod_data_o,
  output logic             mod_valid_o,
  output logic             rf_on_o,
  output logic             event_one_output_o,
  output logic             filter_ok_o,
  output logic             irq_o
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  localparam int unsigned IRQ_W_L = pmp_pkg::IRQ_W;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_PLAY = 3'b100
  } mode_t;

  typedef struct packed {
    mode_t          mode;
    logic [4:0]     ctrl;
    logic [IRQ_W_L-1:0] irq_st;
    logic [IRQ_W_L-1:0] irq_msk;
    logic [15:0]    err;
    logic [AW:0]    wptr;
    logic [AW:0]    plen;
    logic [AW-1:0]  rptr;
    logic [15:0]    symdiv;
    logic [15:0]    divcnt;
    logic [15:0]    free_bytes;
    logic [15:0]    slot_bits;
    logic [15:0]    field_bits;
    logic [15:0]    bitcnt;
    logic [15:0]    filt_len;
    logic           filt_ok;
    logic           ext_clk_d;
    logic           mod_data;
    logic           mod_valid;
    logic           rf_on;
    logic           event_one;
    logic [31:0]    rdata;
    logic           irq;
  } state_t;

  localparam logic [AW:0] DEPTH_L = (AW+1)'(DEPTH);
  localparam logic [AW:0] MINLEN  = (AW+1)'(pmp_pkg::MIN_FILE_BYTES);

  state_t              st_ff;
  state_t              nxt_st;
  pmp_pkg::bus_req_t   req;
  pmp_pkg::play_out_t  po;
  logic [7:0]          mem_rd;
  logic                mem_we;
  logic [3:0]          pins_s;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ****************************************************************
  // Submodules
  // ****************************************************************
  // External pins pass two flip-flops before any logic reads them.
  pmp_sync #(.W(4)) u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({external_burst_input_i, ext_symbol_sync_i,
                 ext_data_clk_i, ext_data_i}),
    .sync_o    (pins_s)
  );

  // Pattern storage, written by downloads and read by playback.
  pmp_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .sys_clk_i (sys_clk_i),
    .we_i      (mem_we),
    .waddr_i   (st_ff.wptr[AW-1:0]),
    .wdata_i   (req.wdata[7:0]),
    .raddr_i   (st_ff.rptr),
    .rdata_o   (mem_rd)
  );

  assign mem_we = req.wr && req.addr == pmp_pkg::OFS_PDATA
                  && st_ff.mode == ST_LOAD && st_ff.wptr < DEPTH_L;
  assign po = pmp_pkg::decode_byte(mem_rd);

  // Checks a filter descriptor: taps, complex flag, span and kind.
  function automatic logic filt_fits(input logic [31:0] d);
    logic [15:0] taps;
    logic [9:0]  span;
    logic [15:0] lim;
    taps = d[15:0];
    span = d[25:16];
    lim  = d[28] ? 16'(pmp_pkg::MAX_TAPS_COMPLEX)
                 : 16'(pmp_pkg::MAX_TAPS_REAL);
    filt_fits = taps <= lim;
    case (d[27:26])
      pmp_pkg::FK_REALTIME:
        filt_fits = filt_fits && span <= 10'(pmp_pkg::SPAN_REALTIME);
      pmp_pkg::FK_CUSTOM:
        filt_fits = filt_fits && span <= 10'(pmp_pkg::SPAN_CUSTOM);
      default:
        filt_fits = filt_fits && span <= 10'(pmp_pkg::SPAN_EQUAL);
    endcase
  endfunction : filt_fits

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [IRQ_W_L-1:0] ev;
    logic               sym;
    logic               ext_edge;
    logic               lastbit;
    ev       = '0;
    lastbit  = 1'b0;
    nxt_st   = st_ff;
    ext_edge = pins_s[1] && !st_ff.ext_clk_d;
    nxt_st.ext_clk_d = pins_s[1];
    nxt_st.rdata     = '0;
    nxt_st.event_one = 1'b0;
    nxt_st.mod_valid = 1'b0;
    // Symbol rate enable from the divider.
    sym = 1'b0;
    if (st_ff.divcnt >= st_ff.symdiv)
    begin
      nxt_st.divcnt = '0;
      sym = 1'b1;
    end
    else
      nxt_st.divcnt = st_ff.divcnt + 16'h0001;

    // Register writes.
    if (req.wr)
    begin
      case (req.addr)
        pmp_pkg::OFS_CTRL:
        begin
          nxt_st.ctrl = req.wdata[4:0];
          if (req.wdata[pmp_pkg::CTL_DLSTART])
          begin
            nxt_st.mode = ST_LOAD;
            nxt_st.wptr = '0;
            nxt_st.err  = pmp_pkg::ERR_NONE;
          end
        end
        pmp_pkg::OFS_IRQ_MSK: nxt_st.irq_msk = req.wdata[IRQ_W_L-1:0];
        pmp_pkg::OFS_SYMDIV:  nxt_st.symdiv  = req.wdata[15:0];
        pmp_pkg::OFS_FREE:    nxt_st.free_bytes = req.wdata[15:0];
        pmp_pkg::OFS_SLOT:    nxt_st.slot_bits  = req.wdata[15:0];
        pmp_pkg::OFS_FIELD:   nxt_st.field_bits = req.wdata[15:0];
        pmp_pkg::OFS_PDATA:
          if (st_ff.mode == ST_LOAD)
          begin
            if (st_ff.wptr < DEPTH_L)
              nxt_st.wptr = st_ff.wptr + 1'b1;
            else
            begin
              nxt_st.err  = pmp_pkg::ERR_TOO_MUCH;
              nxt_st.mode = ST_IDLE;
              ev[pmp_pkg::IRQ_ERR] = 1'b1;
            end
          end
        pmp_pkg::OFS_PLEN:
          if (st_ff.mode == ST_LOAD)
          begin
            // Closing a download; too short files never play.
            nxt_st.plen = st_ff.wptr;
            nxt_st.rptr = '0;
            nxt_st.mode = (st_ff.wptr >= MINLEN) ? ST_PLAY : ST_IDLE;
            ev[pmp_pkg::IRQ_DLDONE] = 1'b1;
          end
        pmp_pkg::OFS_FILT:
        begin
          nxt_st.filt_len = req.wdata[15:0];
          nxt_st.filt_ok  = filt_fits(req.wdata);
          if (req.wdata[15:0] > (req.wdata[28]
              ? 16'(pmp_pkg::MAX_TAPS_COMPLEX)
              : 16'(pmp_pkg::MAX_TAPS_REAL)))
          begin
            nxt_st.err = pmp_pkg::ERR_TOO_MUCH;
            ev[pmp_pkg::IRQ_ERR] = 1'b1;
          end
          else if (req.wdata[31:29] != 3'h0
                   || {3'h0, req.wdata[15:0], 1'b0} >
                      {3'h0, st_ff.free_bytes, 1'b0})
          begin
            nxt_st.err = pmp_pkg::ERR_OUT_OF_MEM;
            ev[pmp_pkg::IRQ_ERR] = 1'b1;
          end
          if (!filt_fits(req.wdata))
            ev[pmp_pkg::IRQ_FILTBAD] = 1'b1;
        end
        default: ;
      endcase
    end

    // Playback from pattern memory or external pins.
    if (st_ff.ctrl[pmp_pkg::CTL_EXTSRC])
    begin
      // Real-time data sampled on its own clock edge.
      if (ext_edge)
      begin
        nxt_st.mod_data  = pins_s[0];
        nxt_st.mod_valid = 1'b1;
        nxt_st.rf_on     = st_ff.ctrl[pmp_pkg::CTL_EXTFRM]
                           ? pins_s[3] : 1'b1;
        nxt_st.event_one = pins_s[2];
      end
    end
    else if (st_ff.mode == ST_PLAY && st_ff.ctrl[pmp_pkg::CTL_RUN] && sym)
    begin
      nxt_st.mod_data  = po.data;
      nxt_st.mod_valid = po.burst;
      nxt_st.rf_on     = po.burst;
      nxt_st.event_one = po.event_one;
      if (st_ff.ctrl[pmp_pkg::CTL_EXTFRM])
        nxt_st.rf_on = po.burst & pins_s[3];
      // Framed user data restarts after the last whole field (field_bits).
      lastbit = st_ff.ctrl[pmp_pkg::CTL_USRFRM]
                && st_ff.field_bits != 16'h0000
                && st_ff.bitcnt + 16'h0001 >= st_ff.field_bits
                && {16'h0, st_ff.rptr} + 32'h1 +
                   {16'h0, st_ff.field_bits} > {23'h0, st_ff.plen};
      nxt_st.bitcnt = (st_ff.bitcnt + 16'h0001 >= st_ff.field_bits)
                      ? 16'h0000 : st_ff.bitcnt + 16'h0001;
      if (mem_rd[pmp_pkg::BIT_RESTART] || lastbit
          || {1'b0, st_ff.rptr} + 1'b1 >= st_ff.plen)
      begin
        nxt_st.rptr   = '0;
        nxt_st.bitcnt = 16'h0000;
        ev[pmp_pkg::IRQ_RESTART] = 1'b1;
      end
      else
        nxt_st.rptr = st_ff.rptr + 1'b1;
    end
    else if (st_ff.mode != ST_PLAY)
      nxt_st.rf_on = 1'b0;

    // Register reads, answered in the next cycle.
    if (req.rd)
    begin
      case (req.addr)
        pmp_pkg::OFS_CTRL:    nxt_st.rdata = {27'h0, st_ff.ctrl};
        pmp_pkg::OFS_STATUS:  nxt_st.rdata = {14'h0, st_ff.mode,
                                st_ff.filt_ok, 6'h0, st_ff.rptr};
        pmp_pkg::OFS_IRQ_ST:  nxt_st.rdata = 32'(st_ff.irq_st);
        pmp_pkg::OFS_IRQ_MSK: nxt_st.rdata = 32'(st_ff.irq_msk);
        pmp_pkg::OFS_ERROR:   nxt_st.rdata = {16'h0, st_ff.err};
        pmp_pkg::OFS_PLEN:    nxt_st.rdata = 32'(st_ff.plen);
        pmp_pkg::OFS_FILT:    nxt_st.rdata = {16'h0, st_ff.filt_len};
        pmp_pkg::OFS_FREE:    nxt_st.rdata = {16'h0, st_ff.free_bytes};
        pmp_pkg::OFS_SLOT:    nxt_st.rdata = {16'h0, st_ff.slot_bits};
        pmp_pkg::OFS_FIELD:   nxt_st.rdata = {16'h0, st_ff.field_bits};
        pmp_pkg::OFS_SYMDIV:  nxt_st.rdata = {16'h0, st_ff.symdiv};
        default:              nxt_st.rdata = 32'h0;
      endcase
    end

    // Sticky status: a set in the same cycle wins over a clear.
    if (req.wr && req.addr == pmp_pkg::OFS_IRQ_ST)
      nxt_st.irq_st = st_ff.irq_st & ~req.wdata[IRQ_W_L-1:0];
    nxt_st.irq_st = nxt_st.irq_st | ev;
    nxt_st.irq    = |(nxt_st.irq_st & nxt_st.irq_msk);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_ff      <= '0;
      st_ff.mode <= ST_IDLE;
    end
    else
      st_ff <= nxt_st;
  end

  assign rdata_o            = st_ff.rdata;
  assign mod_data_o         = st_ff.mod_data;
  assign mod_valid_o        = st_ff.mod_valid;
  assign rf_on_o            = st_ff.rf_on;
  assign event_one_output_o = st_ff.event_one;
  assign filter_ok_o        = st_ff.filt_ok;
  assign irq_o              = st_ff.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_rf_follows_burst;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_ff.mode == ST_PLAY && st_ff.ctrl[2:0] == 3'h1
     && st_ff.divcnt >= st_ff.symdiv && !req.wr)
    |=> (rf_on_o == $past(po.burst));
  endproperty
  a_rf_follows_burst: assert property (p_rf_follows_burst)
    else $error("RF gate does not follow burst bit.");

  property p_event_pulse;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_ff.mode == ST_PLAY && st_ff.ctrl[2:0] == 3'h1
     && st_ff.divcnt >= st_ff.symdiv && po.event_one)
    |=> event_one_output_o ##1 !event_one_output_o;
  endproperty
  a_event_pulse: assert property (p_event_pulse)
    else $error("Event output is not a single pulse.");

  property p_restart_zero;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_ff.mode == ST_PLAY && st_ff.ctrl[2:0] == 3'h1
     && st_ff.divcnt >= st_ff.symdiv && mem_rd[7] && !req.wr)
    |=> (st_ff.rptr == '0);
  endproperty
  a_restart_zero: assert property (p_restart_zero)
    else $error("Playback did not restart at address zero.");

  property p_overflow_err;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (req.wr && req.addr == pmp_pkg::OFS_PDATA && st_ff.mode == ST_LOAD
     && st_ff.wptr >= DEPTH_L) |=> (st_ff.err == pmp_pkg::ERR_TOO_MUCH);
  endproperty
  a_overflow_err: assert property (p_overflow_err)
    else $error("Oversize download not reported.");

  property p_filt_no_mem;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (req.wr && req.addr == pmp_pkg::OFS_FILT && req.wdata[31:29] != 3'h0
     && req.wdata[15:0] <= 16'(pmp_pkg::MAX_TAPS_REAL))
    |=> (st_ff.err == pmp_pkg::ERR_OUT_OF_MEM);
  endproperty
  a_filt_no_mem: assert property (p_filt_no_mem)
    else $error("Filter without room not reported.");

  property p_ext_symbol;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (st_ff.ctrl[pmp_pkg::CTL_EXTSRC] && pins_s[1] && !st_ff.ext_clk_d)
    |=> (mod_valid_o && mod_data_o == $past(pins_s[0]));
  endproperty
  a_ext_symbol: assert property (p_ext_symbol)
    else $error("External data bit not delivered.");

endmodule : pattern_memory_playback

// ===== pattern_memory_playback_test.sv
// Self-checking bench of the pattern memory playback engine.
`timescale 1ns/1ps
module pattern_memory_playback_test;
  localparam int NB = 64;
  logic        sys_clk;
  logic        resetn;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        ext_data;
  logic        ext_clk;
  logic        ext_sync;
  logic        ext_burst;
  logic        mod_data;
  logic        mod_valid;
  logic        rf_on;
  logic        event_one;
  logic        filter_ok;
  logic        irq;
  logic        rd_d;
  logic        play_chk;
  logic        ia;
  logic [31:0] rq_exp [$];
  logic [31:0] rq_msk [$];
  logic [2:0]  pq [$];
  integer      seed = 32'hf820;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          t;

  host_model host (
    .sys_clk_i(sys_clk), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));

  pattern_memory_playback #(.DEPTH(256), .AW(8)) DUT (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .ext_data_i(ext_data), .ext_data_clk_i(ext_clk),
    .ext_symbol_sync_i(ext_sync), .external_burst_input_i(ext_burst),
    .mod_data_o(mod_data), .mod_valid_o(mod_valid), .rf_on_o(rf_on),
    .event_one_output_o(event_one), .filter_ok_o(filter_ok),
    .irq_o(irq));

  // 200 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic compare(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : compare

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Notes the expected word before the read is issued.
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    rq_exp.push_back(e);
    rq_msk.push_back(m);
    host.xfer(1'b0, a, 32'h0);
  endtask : rd_reg

  // Filter descriptor: error bits, complex, kind, span, taps.
  function automatic logic [31:0] fd(input logic [1:0] k, input int s,
                                     input int n, input logic [3:0] h);
    return {h, k, 10'(s), 16'(n)};
  endfunction : fd

  // Read data stand only in the cycle after the strobe, so they are
  // taken at that cycle's falling edge, when everything has settled.
  always @(posedge sys_clk)
    rd_d <= rd;

  // Watcher: oldest note against each result as it appears.
  always @(negedge sys_clk)
  begin
    if (rd_d === 1'b1)
      compare("rdata", rq_exp.pop_front() & rq_msk[0],
              rdata & rq_msk.pop_front());
    if (play_chk === 1'b1 && mod_valid === 1'b1)
    begin
      if (pq.size() > 0)
        compare("play", {29'h0, pq.pop_front()},
                {29'h0, mod_data, rf_on, event_one});
      else
        compare("extra_symbol", 32'h0, 32'h1);
    end
  end

  // Main sequence.
  initial
  begin
    resetn    = 1'b0;
    play_chk  = 1'b0;
    ext_data  = 1'b0;
    ext_clk   = 1'b0;
    ext_sync  = 1'b0;
    ext_burst = 1'b0;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd_reg(pmp_pkg::OFS_ERROR, 32'h0, 32'hffff);
    host.xfer(1'b1, 8'h30, 32'hffffffff);
    rd_reg(8'h30, 32'h0, 32'hffffffff);
    // One byte past the memory is refused.
    host.build(257, seed);
    host.send(257, 1'b0);
    rd_reg(pmp_pkg::OFS_ERROR, 32'hff21, 32'hffff);
    // Span limits of each filter kind, at and one past the limit.
    host.xfer(1'b1, pmp_pkg::OFS_FREE, 32'h1000);
    for (int k = 0; k < 3; k++)
      for (int d = 0; d < 2; d++)
      begin
        host.xfer(1'b1, pmp_pkg::OFS_FILT, fd(2'(k), (k == 0) ? 32 + d :
                  (k == 1) ? 512 + d : 256 + d, 16, 4'h0));
        rd_reg(pmp_pkg::OFS_STATUS, {17'h0, ~d[0], 14'h0}, 32'h4000);
      end
    host.xfer(1'b1, pmp_pkg::OFS_FILT, fd(2'h0, 1, 1025, 4'h0));
    rd_reg(pmp_pkg::OFS_ERROR, 32'hff21, 32'hffff);
    host.xfer(1'b1, pmp_pkg::OFS_FILT, fd(2'h0, 1, 2049, 4'h1));
    rd_reg(pmp_pkg::OFS_ERROR, 32'hff21, 32'hffff);
    host.xfer(1'b1, pmp_pkg::OFS_FILT, fd(2'h0, 1, 16, 4'h2));
    rd_reg(pmp_pkg::OFS_ERROR, 32'hfebf, 32'hffff);
    // Two laps of a good file must play back to back with no gap.
    host.build(NB, seed);
    for (int k = 0; k < 2 * NB; k++)
      pq.push_back({host.pat[k % NB][0], 1'b1, host.pat[k % NB][6]});
    play_chk = 1'b1;
    host.send(NB, 1'b1);
    for (t = 0; t < 3000 && pq.size() > 2 * NB - 1; t++)
    begin
      @(negedge sys_clk);
      #1;
    end
    if (t == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
    repeat (2 * NB - 1) @(negedge sys_clk);
    #1;
    compare("symbols_left", 32'h0, 32'(pq.size()));
    play_chk = 1'b0;
    @(posedge sys_clk);
    rd_reg(pmp_pkg::OFS_IRQ_ST, 32'ha, 32'ha);
    // The mask must change the line while status bits are pending.
    host.xfer(1'b1, pmp_pkg::OFS_IRQ_MSK, 32'h0);
    ia = irq;
    host.xfer(1'b1, pmp_pkg::OFS_IRQ_MSK, 32'hf);
    compare("irq_mask", 32'h1, {31'h0, ia ^ irq});
    host.xfer(1'b1, pmp_pkg::OFS_CTRL, 32'h0);
    host.xfer(1'b1, pmp_pkg::OFS_IRQ_ST, 32'hf);
    host.xfer(1'b1, 8'h30, 32'h0);
    compare("irq_clear", 32'h0, {31'h0, irq});
    rd_reg(pmp_pkg::OFS_IRQ_ST, 32'h0, 32'hf);
    // External data, clock and sync, framed by the burst pin.
    host.xfer(1'b1, pmp_pkg::OFS_CTRL, 32'h7);
    ext_burst <= 1'b1;
    play_chk = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      ext_clk  <= 1'b0;
      ext_data <= 1'($random(seed));
      ext_sync <= (i == 0);
      repeat (4) @(posedge sys_clk);
      pq.push_back({ext_data, 1'b1, 1'(i == 0)});
      ext_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
    repeat (8) @(posedge sys_clk);
    compare("ext_left", 32'h0, 32'(pq.size()));
    play_chk = 1'b0;
    // The gate is taken on a data clock edge, so one is given each time.
    ext_burst <= 1'b0;
    ext_clk   <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ext_clk <= 1'b1;
    repeat (8) @(posedge sys_clk);
    compare("rf_on_low", 32'h0, {31'h0, rf_on});
    ext_burst <= 1'b1;
    ext_clk   <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ext_clk <= 1'b1;
    repeat (8) @(posedge sys_clk);
    compare("rf_on_high", 32'h1, {31'h0, rf_on});
    // Framed data: 60 bytes in 16-byte fields play three whole fields.
    host.xfer(1'b1, pmp_pkg::OFS_FIELD, 32'h10);
    host.build(60, seed);
    for (int k = 0; k < 96; k++)
      pq.push_back({host.pat[k % 48][0], 1'b1, host.pat[k % 48][6]});
    host.send(60, 1'b0);
    play_chk = 1'b1;
    host.xfer(1'b1, pmp_pkg::OFS_CTRL, 32'h11);
    for (t = 0; t < 3000 && pq.size() > 0; t++)
    begin
      @(negedge sys_clk);
      #1;
    end
    play_chk = 1'b0;
    compare("framed_left", 32'h0, 32'(pq.size()));
    end_of_test();
  end
endmodule : pattern_memory_playback_test

// ===== pmp_mem.sv
// Flip-flop pattern memory with one write and one read port.
`timescale 1ns/1ps
module pmp_mem #(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW    = 8
) (
  // Clock.
  input  wire logic          sys_clk_i,
  // Write port.
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  // Read port.
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);

  logic [7:0] mem_ff [DEPTH];

  // Storage carries no reset; playback only reads written bytes.
  always_ff @(posedge sys_clk_i)
  begin
    if (we_i)
      mem_ff[waddr_i] <= wdata_i;
  end

  assign rdata_o = mem_ff[raddr_i];

endmodule : pmp_mem

// ===== pmp_pkg.sv
// Shared constants, field layouts and types of the pattern playback engine.
package pmp_pkg;

  // ****************************************************************
  // Pattern byte layout
  // ****************************************************************
  localparam int unsigned BIT_DATA    = 0;
  localparam int unsigned BIT_RSV1    = 1;
  localparam int unsigned BIT_BURST   = 2;
  localparam int unsigned BIT_RSV3    = 3;
  localparam int unsigned BIT_RSV4    = 4;
  localparam int unsigned BIT_RSV5    = 5;
  localparam int unsigned BIT_EVENT   = 6;
  localparam int unsigned BIT_RESTART = 7;
  localparam int unsigned MIN_FILE_BYTES = 60;

  // ****************************************************************
  // Download limits and error codes
  // ****************************************************************
  localparam int unsigned MAX_TAPS_REAL    = 1024;
  localparam int unsigned MAX_TAPS_COMPLEX = 2048;
  localparam int unsigned SPAN_REALTIME    = 32;
  localparam int unsigned SPAN_CUSTOM      = 512;
  localparam int unsigned SPAN_EQUAL       = 256;
  localparam logic [15:0] ERR_NONE         = 16'h0000;
  localparam logic [15:0] ERR_TOO_MUCH     = 16'hff21; // -223
  localparam logic [15:0] ERR_OUT_OF_MEM   = 16'hfebf; // -321

  // ****************************************************************
  // Register map (word offsets in bytes)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h0c;
  localparam logic [7:0] OFS_ERROR   = 8'h10;
  localparam logic [7:0] OFS_PDATA   = 8'h14;
  localparam logic [7:0] OFS_PLEN    = 8'h18;
  localparam logic [7:0] OFS_FILT    = 8'h1c;
  localparam logic [7:0] OFS_FREE    = 8'h20;
  localparam logic [7:0] OFS_SLOT    = 8'h24;
  localparam logic [7:0] OFS_FIELD   = 8'h28;
  localparam logic [7:0] OFS_SYMDIV  = 8'h2c;

  // Control register bits.
  localparam int unsigned CTL_RUN     = 0;
  localparam int unsigned CTL_EXTSRC  = 1;
  localparam int unsigned CTL_EXTFRM  = 2;
  localparam int unsigned CTL_DLSTART = 3;
  localparam int unsigned CTL_USRFRM  = 4;

  // Interrupt bits.
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned IRQ_ERR     = 0;
  localparam int unsigned IRQ_RESTART = 1;
  localparam int unsigned IRQ_FILTBAD = 2;
  localparam int unsigned IRQ_DLDONE  = 3;

  // Filter kinds in the filter descriptor.
  localparam logic [1:0] FK_REALTIME = 2'h0;
  localparam logic [1:0] FK_CUSTOM   = 2'h1;
  localparam logic [1:0] FK_EQUAL    = 2'h2;

  // Register bus request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // Outputs of one played pattern byte.
  typedef struct packed {
    logic data;
    logic burst;
    logic event_one;
  } play_out_t;

  // Decodes the playable fields of a pattern byte.
  function automatic play_out_t decode_byte(input logic [7:0] b);
    play_out_t p;
    p.burst     = b[BIT_BURST];
    p.data      = b[BIT_DATA] & b[BIT_BURST];
    p.event_one = b[BIT_EVENT];
    return p;
  endfunction : decode_byte

endpackage : pmp_pkg

// ===== pmp_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module pmp_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  // Data.
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  // The first stage is read only by the second stage.
  always_comb
  begin
    nxt_state.meta = async_i;
    nxt_state.sync = state_ff.meta;
  end

  // Registers both stages.
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign sync_o = state_ff.sync;

endmodule : pmp_sync
